// ===== core/cts_pkg.sv
/*
  constants for the charger timing supervisor: durations, counts, reset values.
  assumes a 25 MHz system clock; all counts derive from the nominal times.
*/
package cts_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 25_000_000;        // sys_clk rate
  localparam int unsigned CLK_NS = 40;                // sys_clk period

  // adapter-present deglitch times
  localparam int unsigned DEG_LONG_NOM_MS  = 1300;    // long variant, nominal 1.3 s in ms
  localparam int unsigned DEG_SHORT_NOM_US = 1200;    // short variant, nominal 1.2 ms in us
  localparam int unsigned DEG_FAST_NOM_US  = 10;      // option bit set, nominal 10 us
  localparam int unsigned DEG_LONG_CYC  = DEG_LONG_NOM_MS * (CLK_HZ / 1000);
  localparam int unsigned DEG_SHORT_CYC = DEG_SHORT_NOM_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEG_FAST_CYC  = DEG_FAST_NOM_US * (CLK_HZ / 1_000_000);

  // gate drive dead time, at least one cycle (rounded up)
  localparam int unsigned DEAD_NS  = 20;
  localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;

  // soft-start step
  localparam int unsigned STEP_US  = 240;
  localparam int unsigned STEP_CYC = STEP_US * (CLK_HZ / 1_000_000);
  localparam logic [6:0]  SS_START_CODE = 7'h02;      // 128 mA in 64 mA units
  localparam logic [6:0]  SS_STEP_CODE  = 7'h01;      // one 64 mA step

  // bus clock-low timeout, 30 ms sits inside 25..35 ms
  localparam int unsigned BUS_TO_MS  = 30;
  localparam int unsigned BUS_TO_CYC = BUS_TO_MS * (CLK_HZ / 1000);

  // watchdog periods in ms; counted with a 1 ms prescale tick
  localparam int unsigned MS_CYC   = CLK_HZ / 1000;
  localparam int unsigned WD44_MS  = 44_000;
  localparam int unsigned WD88_MS  = 88_000;
  localparam int unsigned WD175_MS = 175_000;
  localparam logic [1:0]  WD_OFF   = 2'h0;            // disabled code
  localparam logic [1:0]  WD_44    = 2'h1;
  localparam logic [1:0]  WD_88    = 2'h2;
  localparam logic [1:0]  WD_RESET = 2'h3;            // 175 s, value after reset
endpackage

// ===== core/cts_sync.sv
/*
  two flip-flop synchroniser for one level from outside sys_clk.
  assumes the input is a plain level; only the dout stage reads the first stage.
*/
`timescale 1ns/100ps
`default_nettype none
module cts_sync (
  input  wire logic sys_clk,   // system clock
  input  wire logic resetn,    // async reset, active low
  input  wire logic din,       // async level
  output logic      dout       // synchronised level
);
  logic meta;                  // first stage, read only by dout

  // plain two-stage chain
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== core/cts_top.sv
/*
  charger timing supervisor: adapter deglitch, gate dead time, soft-start,
  bus clock-low release and host watchdog.
  assumes a 25 MHz sys_clk; pin inputs are asynchronous and synchronised here.
*/
// Functional notes
// - long variant default deglitch about 1.3 s
// - short variant default deglitch about 1.2 ms
// - option bit set: deglitch about 10 us
// - dead time between low and high drive
// - each soft-start step held 240 us
// - release bus after clock low 25-35 ms
// - host stretch 10 ms, device 25 ms
// - watchdog code 01 expires near 44 s
// - watchdog code 10 expires near 88 s
// - watchdog code resets to 11, 175 s
// - disable code off; rewrite resumes charging
// - expiry suspends charge; voltage/current write restarts
// - soft-start from 128 mA in 64 mA steps
`timescale 1ns/100ps
`default_nettype none
module cts_top
  import cts_pkg::*;
#(
  parameter int unsigned DEG_LONG  = cts_pkg::DEG_LONG_CYC,  // long deglitch cycles
  parameter int unsigned DEG_SHORT = cts_pkg::DEG_SHORT_CYC, // short deglitch cycles
  parameter int unsigned BUS_TO    = cts_pkg::BUS_TO_CYC,    // bus timeout cycles
  parameter int unsigned MS_TICK   = cts_pkg::MS_CYC,        // cycles per ms tick
  parameter bit          LONG_VARIANT = 1'b1                 // 1: long, 0: short
) (
  input  wire logic       sys_clk,                // 25 MHz system clock
  input  wire logic       resetn,                 // async reset, active low
  input  wire logic       adapter_detect_input,   // comparator level, async
  input  wire logic       deglitch_fast,          // option bit 15 level
  input  wire logic       pwm_high,               // requested phase, 1 high side
  input  wire logic       bus_clk_in,             // bus clock pin, async
  input  wire logic       wd_period_wr,           // pulse: period field written
  input  wire logic [1:0] wd_period,              // period field data
  input  wire logic       limit_wr,               // pulse: voltage/current write
  input  wire logic       charge_req,             // charging wanted, same clock
  input  wire logic       continuous_conduction,  // steps only advance in this mode
  input  wire logic [6:0] current_limit,          // programmed limit, 64 mA units
  output logic            adapter_present_output, // deglitched adapter state
  output logic            high_drive,             // high-side gate on
  output logic            low_drive,              // low-side gate on
  output logic            bus_release,            // pulse: reset bus interface
  output logic            charge_active,          // charging allowed
  output logic [6:0]      current_code,           // soft-start current setting
  output logic            wd_expired              // watchdog has fired
);
  import cts_pkg::*;

  // synchronised pins
  logic adp_s;   // adapter detect
  logic scl_s;   // bus clock

  cts_sync u_sync_adp (.sys_clk(sys_clk), .resetn(resetn),
                       .din(adapter_detect_input), .dout(adp_s));
  cts_sync u_sync_scl (.sys_clk(sys_clk), .resetn(resetn),
                       .din(bus_clk_in), .dout(scl_s));

  // deglitch: the output follows only after the input holds its new level
  logic [25:0] deg_cnt, next_deg_cnt;     // hold counter
  logic        next_adp;                  // next output level
  logic [25:0] deg_term;                  // selected terminal count

  always_comb begin
    if (deglitch_fast)
      deg_term = 26'(DEG_FAST_CYC);
    else if (LONG_VARIANT)
      deg_term = 26'(DEG_LONG);
    else
      deg_term = 26'(DEG_SHORT);
    next_deg_cnt = '0;
    next_adp     = adapter_present_output;
    if (adp_s != adapter_present_output) begin
      if (deg_cnt >= deg_term - 26'd1)
        next_adp = adp_s;
      else
        next_deg_cnt = deg_cnt + 26'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      deg_cnt                <= '0;
      adapter_present_output <= 1'b0;
    end else begin
      deg_cnt                <= next_deg_cnt;
      adapter_present_output <= next_adp;
    end
  end

  // dead time: both gates off for DEAD_CYC + 1 cycles between phases
  logic [1:0] dead_cnt, next_dead_cnt;    // gap counter
  logic       next_hi, next_lo;           // next gate levels

  always_comb begin
    next_dead_cnt = dead_cnt;
    next_hi       = high_drive;
    next_lo       = low_drive;
    if ((high_drive && !pwm_high) || (low_drive && pwm_high)) begin
      next_hi       = 1'b0;
      next_lo       = 1'b0;
      next_dead_cnt = 2'(DEAD_CYC);
    end else if (dead_cnt != 2'd0) begin
      next_dead_cnt = dead_cnt - 2'd1;
    end else if (!high_drive && !low_drive) begin
      next_hi = pwm_high;
      next_lo = !pwm_high;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dead_cnt   <= 2'd0;
      high_drive <= 1'b0;
      low_drive  <= 1'b0;
    end else begin
      dead_cnt   <= next_dead_cnt;
      high_drive <= next_hi;
      low_drive  <= next_lo;
    end
  end

  // bus clock-low watch; one release pulse per low stretch
  logic [19:0] low_cnt, next_low_cnt;     // clock-low time
  logic        next_rel;                  // next release pulse

  always_comb begin
    next_rel     = 1'b0;
    next_low_cnt = '0;
    if (!scl_s) begin
      next_low_cnt = low_cnt;
      if (low_cnt < 20'(BUS_TO))
        next_low_cnt = low_cnt + 20'd1;
      next_rel = (low_cnt == 20'(BUS_TO) - 20'd1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt     <= '0;
      bus_release <= 1'b0;
    end else begin
      low_cnt     <= next_low_cnt;
      bus_release <= next_rel;
    end
  end

  // watchdog: 1 ms prescaler and a ms counter against the selected period
  logic [14:0] pre_cnt, next_pre_cnt;     // cycles within a ms
  logic [17:0] wd_cnt, next_wd_cnt;       // elapsed ms
  logic [1:0]  wd_code, next_wd_code;     // period field copy
  logic        next_exp;                  // next expiry flag
  logic [17:0] wd_term;                   // selected period in ms
  logic        ms_tick;                   // one ms elapsed

  always_comb begin
    case (wd_code)
      WD_44:   wd_term = 18'(WD44_MS);
      WD_88:   wd_term = 18'(WD88_MS);
      default: wd_term = 18'(WD175_MS);
    endcase
    ms_tick      = (pre_cnt == 15'(MS_TICK - 1));
    next_pre_cnt = ms_tick ? 15'd0 : pre_cnt + 15'd1;
    next_wd_code = wd_period_wr ? wd_period : wd_code;
    next_wd_cnt  = wd_cnt;
    next_exp     = wd_expired;
    if (limit_wr || wd_period_wr) begin
      next_wd_cnt = '0;
      next_exp    = 1'b0;
    end else if (wd_code != WD_OFF && !wd_expired && ms_tick) begin
      if (wd_cnt >= wd_term - 18'd1)
        next_exp = 1'b1;
      else
        next_wd_cnt = wd_cnt + 18'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt    <= '0;
      wd_cnt     <= '0;
      wd_code    <= WD_RESET;
      wd_expired <= 1'b0;
    end else begin
      pre_cnt    <= next_pre_cnt;
      wd_cnt     <= next_wd_cnt;
      wd_code    <= next_wd_code;
      wd_expired <= next_exp;
    end
  end

  // soft-start: restart at 128 mA, or at the limit if lower, each time charging turns on
  logic [12:0] step_cnt, next_step_cnt;   // step hold timer
  logic [6:0]  next_code;                 // next current code
  logic        next_act;                  // next charge enable
  logic        run;                       // charging allowed now

  always_comb begin
    run           = charge_req && !next_exp;
    next_act      = run;
    next_code     = current_code;
    next_step_cnt = '0;
    if (!run) begin
      next_code = '0;
    end else if (!charge_active) begin
      next_code = (current_limit < SS_START_CODE) ? current_limit : SS_START_CODE;
    end else if (current_code < current_limit) begin
      next_step_cnt = step_cnt;
      if (continuous_conduction) begin
        if (step_cnt >= 13'(STEP_CYC - 1)) begin
          next_code     = current_code + SS_STEP_CODE;
          next_step_cnt = '0;
        end else begin
          next_step_cnt = step_cnt + 13'd1;
        end
      end
    end else begin
      next_code = current_limit;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      step_cnt      <= '0;
      current_code  <= '0;
      charge_active <= 1'b0;
    end else begin
      step_cnt      <= next_step_cnt;
      current_code  <= next_code;
      charge_active <= next_act;
    end
  end

  // checks
  a_dead_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(high_drive) |-> !low_drive) else $error("gates overlap");
  a_no_overlap: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(high_drive && low_drive)) else $error("both gates on");
  a_ss_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(charge_active) && current_limit >= SS_START_CODE |-> current_code == SS_START_CODE)
    else $error("soft-start not 128 mA");
  a_ss_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    charge_active && $past(charge_active) && current_code != $past(current_code)
    |-> current_code == $past(current_code) + SS_STEP_CODE || current_code == current_limit)
    else $error("bad step size");
  a_wd_halt: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_expired |-> !charge_active) else $error("charging after expiry");
  a_wd_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    limit_wr |=> !wd_expired && wd_cnt == 0) else $error("write did not restart");
  a_wd_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_code == WD_OFF && !wd_expired |=> !wd_expired) else $error("disabled dog fired");
  a_bus_rel: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_release |-> !scl_s || $past(!scl_s)) else $error("release with clock high");
  a_deg_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    adp_s != adapter_present_output && deglitch_fast |-> ##[1:300] adapter_present_output == adp_s || adp_s != $past(adp_s))
    else $error("fast deglitch too slow");
endmodule
`default_nettype wire

// ===== dv/cts_host_model.sv
/*
  bus host model: drives the bus clock from a timebase of its own.
  assumes the bench commands frames and a stuck-low fault; idle is pulled up.
*/
`timescale 1ns/100ps
`default_nettype none
module cts_host_model (
  input  wire logic run,      // clock a frame
  input  wire logic hold_low, // fault: keep the clock low
  output logic      bus_clk   // bus clock line
);
  // 320 ns period; the odd start offset keeps the phase unrelated to sys_clk
  initial begin
    bus_clk = 1'b1;
    #37;
    forever begin
      #160;
      if (hold_low) begin
        bus_clk = 1'b0; // stuck low on command
      end else if (run) begin
        bus_clk = ~bus_clk; // 160 ns low, far under the stretch limit
      end else begin
        bus_clk = 1'b1; // clock stands high outside frames
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_charger_timing_supervisor.sv
/*
  self-checking bench for the timing supervisor with shortened counts.
  assumes cts_pkg constants and the host model; one ms tick per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_charger_timing_supervisor;
  logic       sys_clk = 1'b0;  // 25 MHz
  logic       resetn  = 1'b0;  // async reset
  logic       adi     = 1'b0;  // adapter pin
  logic       fast    = 1'b1;  // fast (10 us) deglitch select
  logic       pwm     = 1'b0;  // requested phase
  logic       wr      = 1'b0;  // period write pulse
  logic       lwr     = 1'b0;  // limit write pulse
  logic       req     = 1'b0;  // charge wanted
  logic       cc      = 1'b1;  // continuous conduction
  logic       run     = 1'b0;  // host frame
  logic       hold    = 1'b0;  // host fault
  logic [1:0] wdp     = 2'h3;  // period field data
  logic [6:0] lim     = 7'h04; // current limit
  logic       bus_clk, adapter_present_output, high_drive, low_drive;
  logic       bus_release, charge_active, wd_expired, ph, pl;
  logic [6:0] current_code;    // soft-start code
  logic       adp_short;       // adapter output of the short-delay variant
  int         m = 0;           // second leg of a split wait
  logic [31:0] r;              // random draw
  int         num_errors = 0, comparisons = 0, n = 0, rel_cnt = 0;

  always #20 sys_clk = ~sys_clk;

  cts_host_model u_host (.run(run), .hold_low(hold), .bus_clk(bus_clk));

  cts_top #(.DEG_LONG(100), .DEG_SHORT(50), .BUS_TO(200), .MS_TICK(1), .LONG_VARIANT(1'b1))
  u_dut (.sys_clk(sys_clk), .resetn(resetn), .adapter_detect_input(adi),
    .deglitch_fast(fast), .pwm_high(pwm), .bus_clk_in(bus_clk), .wd_period_wr(wr),
    .wd_period(wdp), .limit_wr(lwr), .charge_req(req), .continuous_conduction(cc),
    .current_limit(lim), .adapter_present_output(adapter_present_output),
    .high_drive(high_drive), .low_drive(low_drive), .bus_release(bus_release),
    .charge_active(charge_active), .current_code(current_code), .wd_expired(wd_expired));

  // short-delay variant on the same pins, only its adapter output is watched
  cts_top #(.DEG_LONG(100), .DEG_SHORT(50), .BUS_TO(200), .MS_TICK(1), .LONG_VARIANT(1'b0))
  u_dut_short (.sys_clk(sys_clk), .resetn(resetn), .adapter_detect_input(adi),
    .deglitch_fast(fast), .pwm_high(pwm), .bus_clk_in(bus_clk), .wd_period_wr(wr),
    .wd_period(wdp), .limit_wr(lwr), .charge_req(req), .continuous_conduction(cc),
    .current_limit(lim), .adapter_present_output(adp_short), .high_drive(), .low_drive(),
    .bus_release(), .charge_active(), .current_code(), .wd_expired());

  // one place for every comparison
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // pick an output by index so one wait loop serves all
  function automatic logic pick(int k);
    case (k)
      0: return adapter_present_output;
      1: return wd_expired;
      3: return adp_short;
      default: return bus_release;
    endcase
  endfunction

  // bounded wait, counts edges until the output shows v
  task automatic until_out(int k, logic v, int lmt, output int cnt);
    cnt = 0;
    while (pick(k) !== v && cnt < lmt) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // gates never overlap and never swap without an idle cycle between
  always @(negedge sys_clk) begin
    if (resetn) begin
      check("gate overlap", high_drive & low_drive, 0);
      check("dead cycle", (ph & low_drive) | (pl & high_drive), 0);
    end
    ph = high_drive;
    pl = low_drive;
  end

  // release pulses are counted mid-cycle, where the one-cycle pulse stands settled
  always @(negedge sys_clk) if (bus_release === 1'b1) rel_cnt++;

  // hang guard: the tests need about 93k cycles, this fires near 97.5k
  initial begin
    #3900000;
    num_errors++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(32'h26cb));
    cyc(4);
    check("reset outs", {adapter_present_output, high_drive, low_drive, bus_release,
      charge_active, current_code, wd_expired}, 0);
    @(posedge sys_clk) resetn <= 1'b1;
    // soft-start from two units, one step per step time, stops at limit
    @(posedge sys_clk) req <= 1'b1;
    cyc(2);
    check("start code", current_code, 7'h02);
    for (int i = 3; i <= 4; i++) begin
      n = 0;
      while (current_code !== i[6:0] && n < 7000) begin
        cyc(1);
        n++;
      end
      check("step time", n >= cts_pkg::STEP_CYC - 2 && n <= cts_pkg::STEP_CYC + 2, 1);
    end
    cyc(7000);
    check("limit code", current_code, 7'h04);
    // without continuous conduction a raised limit is not stepped toward
    @(posedge sys_clk) cc <= 1'b0;
    lim <= 7'h05;
    cyc(6100);
    check("cc hold", current_code, 7'h04);
    @(posedge sys_clk) cc <= 1'b1;
    lim <= 7'h04;
    // short glitches are swallowed, a steady level passes after 10 us
    repeat (5) begin
      r = $urandom_range(200, 10);
      @(posedge sys_clk) adi <= 1'b1;
      cyc(r);
      adi <= 1'b0;
      cyc(260);
      check("glitch out", adapter_present_output, 0);
    end
    @(posedge sys_clk) adi <= 1'b1;
    #1;
    until_out(0, 1'b1, 400, n);
    check("fast deglitch", n >= 250 && n <= 256, 1);
    @(posedge sys_clk) fast <= 1'b0;
    adi <= 1'b0;
    #1;
    until_out(3, 1'b0, 400, n);
    check("short deglitch", n >= 50 && n <= 56, 1);
    until_out(0, 1'b0, 400, m);
    check("long deglitch", n + m >= 100 && n + m <= 106, 1);
    // random phase requests land on the right gate
    repeat (20) begin
      r = $urandom;
      @(posedge sys_clk) pwm <= r[0];
      cyc(4);
      check("high gate", high_drive, r[0]);
      check("low gate", low_drive, !r[0]);
    end
    // normal frame never releases; a stuck-low clock releases once
    run <= 1'b1;
    cyc(400);
    check("no release", rel_cnt, 0);
    // let the clock come to rest high so the low stretch starts with the fault
    run <= 1'b0;
    cyc(20);
    hold <= 1'b1;
    until_out(2, 1'b1, 300, n);
    check("release time", n >= 200 && n <= 212, 1);
    cyc(200);
    check("release once", rel_cnt, 1);
    hold <= 1'b0;
    run  <= 1'b0;
    // 44 s code expires, charge stops, limit write resumes
    @(posedge sys_clk) wdp <= 2'h1;
    wr <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
    #1;
    until_out(1, 1'b1, 50000, n);
    check("wd 44", n >= cts_pkg::WD44_MS - 3 && n <= cts_pkg::WD44_MS + 2, 1);
    cyc(2);
    check("suspend", {charge_active, current_code}, 0);
    @(posedge sys_clk) lwr <= 1'b1;
    @(posedge sys_clk) lwr <= 1'b0;
    cyc(2);
    check("resume", {wd_expired, charge_active, current_code}, {1'b0, 1'b1, 7'h02});
    // disabled code never expires
    @(posedge sys_clk) wdp <= 2'h0;
    wr <= 1'b1;
    @(posedge sys_clk) wr <= 1'b0;
    cyc(20000);
    check("wd off", wd_expired, 0);
    check("wd off count", u_dut.wd_cnt, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
